/* File: src/scgc_ctrl.sv */
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
// Summary of operation
// - a set gate bit delivers the clock, the unit runs normally
// - a clear gate bit stops the unit's clock to save power
// - access to an unclocked unit is answered with a bus fault
// - the sleep gate register resets to all zeros
// - sleep gate register at offset 0x118, used during sleep
// - sleep and deep-sleep registers apply only with the select bit set
// - run register while running, deep-sleep register in deep sleep
// - bit 30 gates the ethernet phy clock, read-write, reset zero
// - bit 28 gates the ethernet mac clock, read-write, reset zero
// - bits 6 to 0 gate ports g to a, read-write, reset zero
// - bits 31, 29, 27:7 read zero; software preserves them
module scgc_ctrl (
  input  wire logic                        ref_clk_in,
  input  wire logic                        rst_in,
  input  wire logic [scgc_pkg::ADDR_W-1:0] avs_address_in,
  input  wire logic                        avs_read_in,
  input  wire logic                        avs_write_in,
  input  wire logic [scgc_pkg::DATA_W-1:0] avs_writedata_in,
  input  wire logic [scgc_pkg::BE_W-1:0]   avs_byteenable_in,
  output logic      [scgc_pkg::DATA_W-1:0] avs_readdata_out,
  output logic      [1:0]                  avs_response_out,
  output logic                             avs_waitrequest_out,
  input  wire logic                        sleep_in,
  input  wire logic                        deep_sleep_in,
  input  wire logic [scgc_pkg::UNITS-1:0]  unit_access_in,
  output logic      [scgc_pkg::UNITS-1:0]  unit_fault_out,
  output logic      [scgc_pkg::UNITS-1:0]  unit_clk_en_out,
  output logic      [scgc_pkg::UNITS-1:0]  unit_clk_out,
  output logic                             irq_out
);

  // ==========================================================================
  // declarations
  // ==========================================================================
  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } scgc_bus_e;

  scgc_bus_e                        bus_state_q;
  scgc_bus_e                        bus_state_d;
  logic [scgc_pkg::DATA_W-1:0]      run_gate_q;
  logic [scgc_pkg::DATA_W-1:0]      slp_gate_q;
  logic [scgc_pkg::DATA_W-1:0]      dsl_gate_q;
  logic [scgc_pkg::DATA_W-1:0]      run_cfg_q;
  logic [scgc_pkg::INT_W-1:0]       int_stat_q;
  logic [scgc_pkg::INT_W-1:0]       int_stat_d;
  logic [scgc_pkg::INT_W-1:0]       int_mask_q;
  logic [scgc_pkg::INT_W-1:0]       int_event;
  logic [scgc_pkg::INT_W-1:0]       int_clear;
  logic [scgc_pkg::UNITS-1:0]       active_en_q;
  logic [scgc_pkg::UNITS-1:0]       active_en_d;
  scgc_pkg::scgc_mode_e             mode_q;
  scgc_pkg::scgc_mode_e             mode_d;
  logic [scgc_pkg::DATA_W-1:0]      read_mux;
  logic                             addr_hit;
  logic [scgc_pkg::DATA_W-1:0]      rdata_q;
  logic [1:0]                       resp_q;
  logic [scgc_pkg::DATA_W-1:0]      be_mask;
  logic [scgc_pkg::DATA_W-1:0]      gate_mask;
  logic                             wr_commit;
  logic [scgc_pkg::ADDR_W-1:0]      word_addr;
  logic                             sel_gating;

  scgc_gate_if gate_bus ();

  // ==========================================================================
  // byte enables to bit mask
  // ==========================================================================
  genvar b;
  generate
    for (b = 0; b < scgc_pkg::BE_W; b = b + 1) begin : g_be
      assign be_mask[b*8 +: 8] = {8{avs_byteenable_in[b]}};
    end
  endgenerate

  assign gate_mask = be_mask & scgc_pkg::GATE_WR_MASK;
  assign word_addr = {avs_address_in[scgc_pkg::ADDR_W-1:2], 2'b00};

  // ==========================================================================
  // bus handshake
  // ==========================================================================
  always_comb begin
    bus_state_d = bus_state_q;
    case (bus_state_q)
      BUS_IDLE: begin
        if (avs_read_in || avs_write_in) begin
          bus_state_d = BUS_ACK;
        end
      end
      BUS_ACK: begin
        bus_state_d = BUS_IDLE;
      end
      default: begin
        bus_state_d = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_state_q <= BUS_IDLE;
    end else begin
      bus_state_q <= bus_state_d;
    end
  end

  assign avs_waitrequest_out = (bus_state_q != BUS_ACK);
  assign wr_commit = (bus_state_q == BUS_ACK) && avs_write_in;

  // ==========================================================================
  // address decode and read data
  // ==========================================================================
  always_comb begin
    read_mux = '0;
    addr_hit = 1'b1;
    case (word_addr)
      scgc_pkg::RUN_GATE_OFF: begin
        read_mux = run_gate_q;
      end
      scgc_pkg::SLP_GATE_OFF: begin
        read_mux = slp_gate_q;
      end
      scgc_pkg::DSL_GATE_OFF: begin
        read_mux = dsl_gate_q;
      end
      scgc_pkg::RUN_CFG_OFF: begin
        read_mux = run_cfg_q;
      end
      scgc_pkg::INT_STAT_OFF: begin
        read_mux[scgc_pkg::INT_W-1:0] = int_stat_q;
      end
      scgc_pkg::INT_MASK_OFF: begin
        read_mux[scgc_pkg::INT_W-1:0] = int_mask_q;
      end
      scgc_pkg::STATUS_OFF: begin
        read_mux[scgc_pkg::UNITS-1:0] = active_en_q;
        read_mux[scgc_pkg::MODE_LSB +: 2] = mode_q;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= '0;
      resp_q  <= scgc_pkg::RESP_OKAY;
    end else if (bus_state_q == BUS_IDLE) begin
      if (avs_read_in) begin
        rdata_q <= read_mux;
      end else begin
        rdata_q <= '0;
      end
      if (addr_hit) begin
        resp_q <= scgc_pkg::RESP_OKAY;
      end else begin
        resp_q <= scgc_pkg::RESP_SLVERR;
      end
    end
  end

  assign avs_readdata_out = rdata_q;
  assign avs_response_out = resp_q;

  // ==========================================================================
  // gate registers
  // ==========================================================================
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_gate_q <= scgc_pkg::GATE_RESET;
    end else if (wr_commit && word_addr == scgc_pkg::RUN_GATE_OFF) begin
      run_gate_q <= (run_gate_q & ~gate_mask)
                  | (avs_writedata_in & gate_mask);
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      slp_gate_q <= scgc_pkg::GATE_RESET;
    end else if (wr_commit && word_addr == scgc_pkg::SLP_GATE_OFF) begin
      // phy, mac and port bits only; the rest stay zero
      slp_gate_q <= (slp_gate_q & ~gate_mask)
                  | (avs_writedata_in & gate_mask);
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dsl_gate_q <= scgc_pkg::GATE_RESET;
    end else if (wr_commit && word_addr == scgc_pkg::DSL_GATE_OFF) begin
      dsl_gate_q <= (dsl_gate_q & ~gate_mask)
                  | (avs_writedata_in & gate_mask);
    end
  end

  // ==========================================================================
  // run clock configuration
  // ==========================================================================
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_cfg_q <= scgc_pkg::CFG_RESET;
    end else if (wr_commit && word_addr == scgc_pkg::RUN_CFG_OFF) begin
      if (avs_byteenable_in[scgc_pkg::SEL_BIT / 8]) begin
        run_cfg_q[scgc_pkg::SEL_BIT] <= avs_writedata_in[scgc_pkg::SEL_BIT];
      end
    end
  end

  assign sel_gating = run_cfg_q[scgc_pkg::SEL_BIT];

  // ==========================================================================
  // power mode and active gate set
  // ==========================================================================
  always_comb begin
    mode_d      = scgc_pkg::MODE_RUN;
    active_en_d = scgc_pkg::reg_to_units(run_gate_q);
    if (sel_gating && deep_sleep_in) begin
      mode_d      = scgc_pkg::MODE_DEEP;
      active_en_d = scgc_pkg::reg_to_units(dsl_gate_q);
    end else if (sel_gating && sleep_in) begin
      mode_d      = scgc_pkg::MODE_SLEEP;
      active_en_d = scgc_pkg::reg_to_units(slp_gate_q);
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      active_en_q <= '0;
      mode_q      <= scgc_pkg::MODE_RUN;
    end else begin
      active_en_q <= active_en_d;
      mode_q      <= mode_d;
    end
  end

  assign unit_clk_en_out = active_en_q;

  // ==========================================================================
  // gated clocks
  // ==========================================================================
  genvar u;
  generate
    for (u = 0; u < scgc_pkg::UNITS; u = u + 1) begin : g_gate
      scgc_clk_cell u_cell (
        .clk_in   (ref_clk_in),
        .rst_in   (rst_in),
        .en_in    (active_en_q[u]),
        .gclk_out (unit_clk_out[u])
      );
    end
  endgenerate

  // ==========================================================================
  // unit access fault check
  // ==========================================================================
  assign gate_bus.en     = active_en_q;
  assign gate_bus.access = unit_access_in;

  scgc_fault_chk u_fault (
    .clk_in (ref_clk_in),
    .rst_in (rst_in),
    .gate   (gate_bus.chk)
  );

  assign unit_fault_out = gate_bus.fault;

  // ==========================================================================
  // interrupts
  // ==========================================================================
  assign int_event[scgc_pkg::INT_FAULT]  = |gate_bus.fault;
  assign int_event[scgc_pkg::INT_CHANGE] = (active_en_d != active_en_q);

  always_comb begin
    int_clear = '0;
    if (wr_commit && word_addr == scgc_pkg::INT_STAT_OFF
        && avs_byteenable_in[0]) begin
      int_clear = avs_writedata_in[scgc_pkg::INT_W-1:0];
    end
    // set wins over a clear in the same cycle
    int_stat_d = (int_stat_q & ~int_clear) | int_event;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      int_stat_q <= '0;
    end else begin
      int_stat_q <= int_stat_d;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      int_mask_q <= '0;
    end else if (wr_commit && word_addr == scgc_pkg::INT_MASK_OFF
                 && avs_byteenable_in[0]) begin
      int_mask_q <= avs_writedata_in[scgc_pkg::INT_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(int_stat_d & int_mask_q);
    end
  end

endmodule

/* File: src/scgc_pkg.sv */
package scgc_pkg;

  // ==========================================================================
  // bus and register map
  // ==========================================================================
  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned BE_W         = 4;
  localparam logic [11:0] RUN_GATE_OFF = 12'h108;
  localparam logic [11:0] SLP_GATE_OFF = 12'h118;
  localparam logic [11:0] DSL_GATE_OFF = 12'h128;
  localparam logic [11:0] RUN_CFG_OFF  = 12'h060;
  localparam logic [11:0] INT_STAT_OFF = 12'h200;
  localparam logic [11:0] INT_MASK_OFF = 12'h204;
  localparam logic [11:0] STATUS_OFF   = 12'h208;

  // ==========================================================================
  // field layout and reset values
  // ==========================================================================
  localparam int unsigned UNITS        = 9;
  localparam int unsigned PORT_LSB     = 0;
  localparam int unsigned PORT_W       = 7;
  localparam int unsigned MAC_BIT      = 28;
  localparam int unsigned PHY_BIT      = 30;
  localparam int unsigned MAC_UNIT     = 7;
  localparam int unsigned PHY_UNIT     = 8;
  localparam int unsigned SEL_BIT      = 0;
  localparam int unsigned INT_FAULT    = 0;
  localparam int unsigned INT_CHANGE   = 1;
  localparam int unsigned INT_W        = 2;
  localparam int unsigned MODE_LSB     = 16;
  localparam logic [31:0] GATE_RESET   = 32'h0000_0000;
  localparam logic [31:0] GATE_WR_MASK = 32'h5000_007F;
  localparam logic [31:0] CFG_RESET    = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ==========================================================================
  // power modes
  // ==========================================================================
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_DEEP
  } scgc_mode_e;

  function automatic logic [UNITS-1:0] reg_to_units(input logic [31:0] r);
    reg_to_units = {r[PHY_BIT], r[MAC_BIT], r[PORT_LSB +: PORT_W]};
  endfunction

endpackage

/* File: src/scgc_gate_if.sv */
`timescale 1ns/1ps
interface scgc_gate_if;
  logic [scgc_pkg::UNITS-1:0] en;
  logic [scgc_pkg::UNITS-1:0] access;
  logic [scgc_pkg::UNITS-1:0] fault;

  modport ctrl (output en, output access, input fault);
  modport chk  (input en, input access, output fault);
endinterface

/* File: src/scgc_clk_cell.sv */
`timescale 1ns/1ps
module scgc_clk_cell (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic en_in,
  output logic      gclk_out
);

  // ==========================================================================
  // enable held over the high phase
  // ==========================================================================
  logic en_low_q;

  always_ff @(negedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      en_low_q <= 1'b0;
    end else begin
      en_low_q <= en_in;
    end
  end

  assign gclk_out = clk_in & en_low_q;

endmodule

/* File: src/scgc_fault_chk.sv */
`timescale 1ns/1ps
module scgc_fault_chk (
  input  wire logic  clk_in,
  input  wire logic  rst_in,
  scgc_gate_if.chk   gate
);

  // ==========================================================================
  // access to an unclocked unit faults
  // ==========================================================================
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      gate.fault <= '0;
    end else begin
      gate.fault <= gate.access & ~gate.en;
    end
  end

endmodule

/* File: tb/scgc_ctrl_sva.sv */
`timescale 1ns/1ps
module scgc_ctrl_sva (
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  input wire logic [11:0] avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic [1:0]  avs_response_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        sleep_in,
  input wire logic        deep_sleep_in,
  input wire logic [8:0]  unit_access_in,
  input wire logic [8:0]  unit_fault_out,
  input wire logic [8:0]  unit_clk_en_out,
  input wire logic [8:0]  unit_clk_out,
  input wire logic        irq_out
);
  // ==========================================================================
  // address decode
  // ==========================================================================
  logic [11:0] wa;
  logic        gate;
  logic        mapped;
  logic        rd_ok;
  assign wa     = {avs_address_in[11:2], 2'b00};
  assign gate   = wa inside {scgc_pkg::RUN_GATE_OFF, scgc_pkg::SLP_GATE_OFF,
                             scgc_pkg::DSL_GATE_OFF};
  assign mapped = gate || wa inside {scgc_pkg::RUN_CFG_OFF,
                  scgc_pkg::INT_STAT_OFF, scgc_pkg::INT_MASK_OFF,
                  scgc_pkg::STATUS_OFF};
  assign rd_ok  = avs_read_in && !avs_waitrequest_out;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  // ==========================================================================
  // properties
  // ==========================================================================
  AST_FAULT_GATED: assert property (
    !$past(rst_in) |->
      unit_fault_out == $past(unit_access_in & ~unit_clk_en_out))
    else $error("fault does not follow gated access");
  AST_ONE_WAIT: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out)
    else $error("request not answered after one wait cycle");
  AST_WAIT_PULSE: assert property (
    !avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  AST_IDLE_WAIT: assert property (
    !(avs_read_in || avs_write_in) |=> avs_waitrequest_out)
    else $error("waitrequest low without a request");
  AST_CLK_FOLLOWS: assert property (
    @(negedge ref_clk_in) disable iff (rst_in)
      unit_clk_out == $past(unit_clk_en_out))
    else $error("gated clock does not follow its enable");
  AST_WR_RDATA: assert property (
    avs_write_in && !avs_waitrequest_out |-> avs_readdata_out == '0)
    else $error("read data not zero on write");
  AST_RO_ZERO: assert property (
    rd_ok && gate |-> (avs_readdata_out & ~scgc_pkg::GATE_WR_MASK) == '0)
    else $error("reserved gate bits read non-zero");
  AST_MAP_RESP: assert property (
    rd_ok |-> avs_response_out == (mapped ? scgc_pkg::RESP_OKAY
                                          : scgc_pkg::RESP_SLVERR))
    else $error("wrong response code");
  AST_EN_CAUSE: assert property (
    !$stable(unit_clk_en_out) |->
         $past(avs_write_in && !avs_waitrequest_out, 2)
      || $past(sleep_in) != $past(sleep_in, 2)
      || $past(deep_sleep_in) != $past(deep_sleep_in, 2))
    else $error("enables changed without cause");
endmodule

bind scgc_ctrl scgc_ctrl_sva u_sva (
  .ref_clk_in          (ref_clk_in),
  .rst_in              (rst_in),
  .avs_address_in      (avs_address_in),
  .avs_read_in         (avs_read_in),
  .avs_write_in        (avs_write_in),
  .avs_writedata_in    (avs_writedata_in),
  .avs_byteenable_in   (avs_byteenable_in),
  .avs_readdata_out    (avs_readdata_out),
  .avs_response_out    (avs_response_out),
  .avs_waitrequest_out (avs_waitrequest_out),
  .sleep_in            (sleep_in),
  .deep_sleep_in       (deep_sleep_in),
  .unit_access_in      (unit_access_in),
  .unit_fault_out      (unit_fault_out),
  .unit_clk_en_out     (unit_clk_en_out),
  .unit_clk_out        (unit_clk_out),
  .irq_out             (irq_out)
);

/* File: tb/scgc_unit_model.sv */
`timescale 1ns/1ps
module scgc_unit_model (
  input  wire logic [8:0] req_in,
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic [8:0] unit_clk_in,
  output logic      [8:0] access_out,
  output logic      [7:0] ticks_out [9]
);
  // ==========================================================================
  // bus access strobes and clock edge counters
  // ==========================================================================
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      access_out <= '0;
    end else begin
      access_out <= req_in;
    end
  end

  for (genvar i = 0; i < 9; i++) begin : g_unit
    always_ff @(posedge unit_clk_in[i] or posedge rst_in) begin
      if (rst_in) begin
        ticks_out[i] <= 8'h00;
      end else begin
        ticks_out[i] <= ticks_out[i] + 8'h01;
      end
    end
  end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    n_tests++; \
    if ((g) !== (e)) begin \
      n_fail++; \
      $display("ERROR %s expected %h seen %h", nm, e, g); \
    end \
  end
module testbench;
  logic        ref_clk_in          = 1'b0;
  logic        rst_in              = 1'b1;
  logic [11:0] avs_address_in      = '0;
  logic        avs_read_in         = 1'b0;
  logic        avs_write_in        = 1'b0;
  logic [31:0] avs_writedata_in    = '0;
  logic [3:0]  avs_byteenable_in   = '0;
  logic [31:0] avs_readdata_out;
  logic [1:0]  avs_response_out;
  logic        avs_waitrequest_out;
  logic        sleep_in            = 1'b0;
  logic        deep_sleep_in       = 1'b0;
  logic [8:0]  unit_access_in;
  logic [8:0]  unit_fault_out;
  logic [8:0]  unit_clk_en_out;
  logic [8:0]  unit_clk_out;
  logic        irq_out;
  logic [8:0]  req                 = '0;
  logic [7:0]  ticks [9];
  logic [31:0] last_rd;
  logic [1:0]  last_rsp;
  int          n_fail              = 0;
  int          n_tests             = 0;

  always #10 ref_clk_in = ~ref_clk_in;

  scgc_ctrl dut (.*);
  scgc_unit_model u_units (.req_in(req), .ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .unit_clk_in(unit_clk_out),
    .access_out(unit_access_in), .ticks_out(ticks));

  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    int k;
    k = 0;
    @(posedge ref_clk_in);
    avs_address_in    <= a;
    avs_writedata_in  <= d;
    avs_byteenable_in <= b;
    avs_write_in      <= w;
    avs_read_in       <= !w;
    forever begin
      @(posedge ref_clk_in);
      k++;
      if (avs_waitrequest_out === 1'b0 || k > 20) break;
    end
    if (k > 20) begin
      n_fail++;
      wrap_up();
    end
    last_rd  = avs_readdata_out;
    last_rsp = avs_response_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
                        input logic [1:0] r);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    `CHK("readdata", e, last_rd)
    `CHK("response", r, last_rsp)
  endtask

  task automatic acc(input logic [8:0] e);
    @(posedge ref_clk_in);
    req <= 9'h1FF;
    @(posedge ref_clk_in);
    req <= 9'h000;
    @(posedge ref_clk_in);
    #1;
    `CHK("unit_fault", e, unit_fault_out)
  endtask

  task automatic chk_clk(input logic [8:0] e);
    logic [7:0] snap [9];
    logic [8:0] run;
    repeat (2) @(posedge ref_clk_in);
    #1;
    snap = ticks;
    repeat (4) @(posedge ref_clk_in);
    #1;
    for (int i = 0; i < 9; i++) run[i] = ticks[i] != snap[i];
    `CHK("unit_clk_en", e, unit_clk_en_out)
    `CHK("unit_clk_run", e, run)
  endtask

  task automatic irq_chk(input logic e);
    @(posedge ref_clk_in);
    #1;
    `CHK("irq", e, irq_out)
  endtask

  // ==========================================================================
  // sequence
  // ==========================================================================
  initial begin
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd_chk(scgc_pkg::SLP_GATE_OFF, 32'h0000_0000, 2'h0);
    rd_chk(scgc_pkg::RUN_GATE_OFF, 32'h0000_0000, 2'h0);
    chk_clk(9'h000);
    acc(9'h1FF);
    $display("test reset_state done");
    bus(1'b1, scgc_pkg::RUN_GATE_OFF, 32'hFFFF_FFFF, 4'hF);
    rd_chk(scgc_pkg::RUN_GATE_OFF, 32'h5000_007F, 2'h0);
    chk_clk(9'h1FF);
    acc(9'h000);
    bus(1'b1, scgc_pkg::RUN_GATE_OFF, 32'h0000_0000, 4'h1);
    rd_chk(scgc_pkg::RUN_GATE_OFF, 32'h5000_0000, 2'h0);
    chk_clk(9'h180);
    acc(9'h07F);
    $display("test bit_map done");
    bus(1'b1, scgc_pkg::SLP_GATE_OFF, 32'hEFFF_FFAA, 4'hF);
    rd_chk(scgc_pkg::SLP_GATE_OFF, 32'h4000_002A, 2'h0);
    bus(1'b1, scgc_pkg::DSL_GATE_OFF, 32'h1000_0041, 4'hF);
    @(posedge ref_clk_in);
    sleep_in <= 1'b1;
    chk_clk(9'h180);
    bus(1'b1, scgc_pkg::RUN_CFG_OFF, 32'h0000_0001, 4'hF);
    chk_clk(9'h12A);
    acc(9'h0D5);
    @(posedge ref_clk_in);
    deep_sleep_in <= 1'b1;
    chk_clk(9'h0C1);
    rd_chk(scgc_pkg::STATUS_OFF, 32'h0002_00C1, 2'h0);
    @(posedge ref_clk_in);
    sleep_in      <= 1'b0;
    deep_sleep_in <= 1'b0;
    chk_clk(9'h180);
    $display("test modes done");
    bus(1'b1, scgc_pkg::INT_STAT_OFF, 32'hFFFF_FFFF, 4'hF);
    bus(1'b1, scgc_pkg::INT_MASK_OFF, 32'h0000_0001, 4'hF);
    irq_chk(1'b0);
    acc(9'h07F);
    irq_chk(1'b1);
    rd_chk(scgc_pkg::INT_STAT_OFF, 32'h0000_0001, 2'h0);
    bus(1'b1, scgc_pkg::INT_MASK_OFF, 32'h0000_0000, 4'hF);
    irq_chk(1'b0);
    bus(1'b1, scgc_pkg::INT_STAT_OFF, 32'h0000_0001, 4'hF);
    rd_chk(scgc_pkg::INT_STAT_OFF, 32'h0000_0000, 2'h0);
    bus(1'b1, scgc_pkg::INT_MASK_OFF, 32'h0000_0002, 4'hF);
    bus(1'b1, scgc_pkg::RUN_GATE_OFF, 32'h5000_007F, 4'hF);
    irq_chk(1'b1);
    rd_chk(scgc_pkg::INT_STAT_OFF, 32'h0000_0002, 2'h0);
    rd_chk(12'hFFC, 32'h0000_0000, 2'h2);
    $display("test interrupts done");
    wrap_up();
  end
endmodule
